// ===== src/acs_map.vh
// register map, field positions, reset values and timing counts of the conversion sequencer
`ifndef ACS_MAP_VH
`define ACS_MAP_VH

// ----------------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------------
`define ACS_ADDR_CTRL0      8'h00
`define ACS_ADDR_CTRL1      8'h04
`define ACS_ADDR_CTRL2      8'h08
`define ACS_ADDR_RESH       8'h0C
`define ACS_ADDR_RESL       8'h10
`define ACS_ADDR_STAT       8'h14
`define ACS_ADDR_PMD        8'h18

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define ACS_CTRL0_ON        0
`define ACS_CTRL0_GO        1
`define ACS_CTRL0_CHS_LSB   2
`define ACS_CTRL0_CHS_MSB   6
`define ACS_CTRL1_TRIG      7
`define ACS_CTRL2_JUST      7
`define ACS_CTRL2_ACQ_LSB   3
`define ACS_CTRL2_ACQ_MSB   5
`define ACS_CTRL2_CLK_LSB   0
`define ACS_CTRL2_CLK_MSB   2
`define ACS_STAT_DONE       0
`define ACS_PMD_DISABLE     0
`define ACS_PMD_IRQ_EN      1

// ----------------------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------------------
`define ACS_RST_REG         8'h00
`define ACS_RST_CHS         5'h00
`define ACS_RST_FIELD3      3'h0
`define ACS_CH_LAST_EXT     5'h1B
`define ACS_TRIAL_START     10'h200
`define ACS_RESP_OKAY       2'h0
`define ACS_RESP_SLVERR     2'h2

// ----------------------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------------------
`define ACS_CONV_TADS       5'd11
`define ACS_WAIT_TADS       5'd2
`define ACS_INSTR_CLKS      5'd4

`endif

// ===== src/acs_tad_gen.v
// conversion bit period tick generator: divided system clock or synchronised rc clock
`timescale 1ns/10ps
`include "acs_map.vh"

module acs_tad_gen (
  input  wire       i_clk,      // system clock
  input  wire       i_srst,     // synchronous reset, also held while module disabled
  input  wire       i_run,      // count while the sequencer is away from idle
  input  wire [2:0] i_clk_sel,  // conversion clock select code
  input  wire       i_rc_clk,   // dedicated rc oscillator, asynchronous
  output reg        o_tick      // one-cycle pulse per conversion bit period
);

  reg  [5:0] div_cnt_r;
  reg        rc_meta_r;
  reg        rc_sync_r;
  reg        rc_prev_r;
  reg  [5:0] div_last;
  wire       rc_sel;

  assign rc_sel = (i_clk_sel[1:0] == 2'b11);

  // ----------------------------------------------------------------------------
  // divider end value per select code
  // ----------------------------------------------------------------------------
  always @* begin
    case (i_clk_sel)
      3'h0:    div_last = 6'h01;
      3'h1:    div_last = 6'h07;
      3'h2:    div_last = 6'h1F;
      3'h4:    div_last = 6'h03;
      3'h5:    div_last = 6'h0F;
      3'h6:    div_last = 6'h3F;
      default: div_last = 6'h01;
    endcase
  end

  // ----------------------------------------------------------------------------
  // period tick
  // ----------------------------------------------------------------------------
  // divider restarts while the sequencer is idle so the first period is a full one
  always @(posedge i_clk) begin
    if (i_srst) begin
      div_cnt_r <= 6'h00;
      rc_meta_r <= 1'b0;
      rc_sync_r <= 1'b0;
      rc_prev_r <= 1'b0;
      o_tick    <= 1'b0;
    end else begin
      rc_meta_r <= i_rc_clk;
      rc_sync_r <= rc_meta_r;
      rc_prev_r <= rc_sync_r;
      o_tick    <= 1'b0;
      if (!i_run) begin
        div_cnt_r <= 6'h00;
      end else if (rc_sel) begin
        o_tick <= rc_sync_r & ~rc_prev_r;
      end else if (div_cnt_r >= div_last) begin
        div_cnt_r <= 6'h00;
        o_tick    <= 1'b1;
      end else begin
        div_cnt_r <= div_cnt_r + 6'h01;
      end
    end
  end

endmodule // acs_tad_gen

// ===== src/acs_top.v
// conversion sequencer for a 10-bit successive-approximation converter, axi4-lite registers
`timescale 1ns/10ps
`include "acs_map.vh"

module acs_top (
  input  wire       i_clk,            // 10 MHz system clock
  input  wire       i_srst,           // synchronous reset, active high
  input  wire [7:0] i_s_axi_awaddr,   // write address
  input  wire       i_s_axi_awvalid,  // write address valid
  output reg        o_s_axi_awready,  // write address ready
  input  wire [31:0] i_s_axi_wdata,   // write data
  input  wire [3:0] i_s_axi_wstrb,    // write strobes
  input  wire       i_s_axi_wvalid,   // write data valid
  output reg        o_s_axi_wready,   // write data ready
  output reg  [1:0] o_s_axi_bresp,    // write response
  output reg        o_s_axi_bvalid,   // write response valid
  input  wire       i_s_axi_bready,   // write response ready
  input  wire [7:0] i_s_axi_araddr,   // read address
  input  wire       i_s_axi_arvalid,  // read address valid
  output reg        o_s_axi_arready,  // read address ready
  output reg [31:0] o_s_axi_rdata,    // read data
  output reg  [1:0] o_s_axi_rresp,    // read response
  output reg        o_s_axi_rvalid,   // read data valid
  input  wire       i_s_axi_rready,   // read data ready
  input  wire       i_cmp_trig,       // compare unit special event pulse
  input  wire       i_ctu_trig,       // charge-time unit special event pulse
  input  wire       i_sleep,          // core is in sleep, level
  input  wire       i_rc_clk,         // dedicated rc oscillator, asynchronous
  input  wire       i_sar_cmp,        // comparator: input at or above trial code
  output reg  [4:0] o_channel_sel,    // sample-and-hold source select
  output reg        o_ext_channel,    // selected source is an external input
  output reg        o_sample_conn,    // channel connected to holding capacitor
  output reg        o_discharge,      // capacitor array discharge
  output reg  [9:0] o_dac_trial,      // trial code for the comparator
  output reg        o_analog_pwr,     // converter analog power
  output reg        o_wake            // one-cycle wake request out of sleep
);

  // ----------------------------------------------------------------------------
  // states
  // ----------------------------------------------------------------------------
  localparam [2:0] ST_IDLE  = 3'd0;
  localparam [2:0] ST_DELAY = 3'd1;
  localparam [2:0] ST_ACQ   = 3'd2;
  localparam [2:0] ST_CONV  = 3'd3;
  localparam [2:0] ST_WAIT  = 3'd4;

  reg  [2:0] state_r;
  reg  [4:0] cnt_r;
  reg  [9:0] trial_r;
  reg        converter_on_r;
  reg        go_r;
  reg  [4:0] channel_select_r;
  reg        trigger_source_sel_r;
  reg        result_justify_r;
  reg  [2:0] acq_time_sel_r;
  reg  [2:0] conv_clock_sel_r;
  reg        conv_done_flag_r;
  reg        module_disable_r;
  reg        irq_en_r;
  reg        sleep_off_r;
  reg  [7:0] result_high_r;
  reg  [7:0] result_low_r;
  reg        cmp_meta_r;
  reg        cmp_sync_r;

  reg        aw_full_r;
  reg        w_full_r;
  reg  [7:0] aw_addr_r;
  reg  [7:0] w_data_r;
  reg        w_lane0_r;
  reg  [4:0] acq_tads;
  reg  [7:0] rd_mux;
  reg        rd_ok;

  wire       core_rst;
  wire       tad_tick;
  wire       rc_sel;
  wire       powered;
  wire       kill;
  wire       wr_do;
  wire       wr_ok;
  wire       wr_ctrl0;
  wire       trig;
  wire       sw_go_set;
  wire       sw_go_clr;
  wire       start_req;
  wire [2:0] run_state;
  wire [3:0] bit_idx;
  wire [9:0] final_code;

  assign core_rst  = i_srst | module_disable_r;
  assign rc_sel    = (conv_clock_sel_r[1:0] == 2'b11);
  assign powered   = converter_on_r & ~sleep_off_r;
  assign kill      = ~powered | (i_sleep & ~rc_sel);
  assign wr_do     = aw_full_r & w_full_r & ~o_s_axi_bvalid;
  assign wr_ok     = wr_do & w_lane0_r;
  assign wr_ctrl0  = wr_ok & (aw_addr_r == `ACS_ADDR_CTRL0);
  assign trig      = trigger_source_sel_r ? i_ctu_trig : i_cmp_trig;
  assign sw_go_set = wr_ctrl0 & w_data_r[`ACS_CTRL0_GO];
  assign sw_go_clr = wr_ctrl0 & ~w_data_r[`ACS_CTRL0_GO];
  assign start_req = (sw_go_set | trig) & converter_on_r & ~go_r;
  assign run_state = rc_sel ? ST_DELAY : ((acq_tads == 5'd0) ? ST_CONV : ST_ACQ);
  assign bit_idx   = 4'd9 - cnt_r[3:0];
  assign final_code = trial_r;

  // ----------------------------------------------------------------------------
  // bit period generator, held in reset while disabled
  // ----------------------------------------------------------------------------
  acs_tad_gen u_tad (
    .i_clk     (i_clk),
    .i_srst    (core_rst),
    .i_run     (state_r != ST_IDLE),
    .i_clk_sel (conv_clock_sel_r),
    .i_rc_clk  (i_rc_clk),
    .o_tick    (tad_tick)
  );

  // ----------------------------------------------------------------------------
  // acquisition length in bit periods
  // ----------------------------------------------------------------------------
  always @* begin
    case (acq_time_sel_r)
      3'h0:    acq_tads = 5'd0;
      3'h1:    acq_tads = 5'd2;
      3'h2:    acq_tads = 5'd4;
      3'h3:    acq_tads = 5'd6;
      3'h4:    acq_tads = 5'd8;
      3'h5:    acq_tads = 5'd12;
      3'h6:    acq_tads = 5'd16;
      default: acq_tads = 5'd20;
    endcase
  end

  // ----------------------------------------------------------------------------
  // axi4-lite slave handshakes
  // ----------------------------------------------------------------------------
  // address and data are taken independently; the write lands once both are held
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_s_axi_awready <= 1'b1;
      o_s_axi_wready  <= 1'b1;
      o_s_axi_bvalid  <= 1'b0;
      o_s_axi_bresp   <= `ACS_RESP_OKAY;
      aw_full_r       <= 1'b0;
      w_full_r        <= 1'b0;
      aw_addr_r       <= 8'h00;
      w_data_r        <= 8'h00;
      w_lane0_r       <= 1'b0;
      o_s_axi_arready <= 1'b1;
      o_s_axi_rvalid  <= 1'b0;
      o_s_axi_rdata   <= 32'h0000_0000;
      o_s_axi_rresp   <= `ACS_RESP_OKAY;
    end else begin
      if (o_s_axi_awready & i_s_axi_awvalid) begin
        aw_full_r       <= 1'b1;
        aw_addr_r       <= i_s_axi_awaddr;
        o_s_axi_awready <= 1'b0;
      end
      if (o_s_axi_wready & i_s_axi_wvalid) begin
        w_full_r       <= 1'b1;
        w_data_r       <= i_s_axi_wdata[7:0];
        w_lane0_r      <= i_s_axi_wstrb[0];
        o_s_axi_wready <= 1'b0;
      end
      if (wr_do) begin
        aw_full_r      <= 1'b0;
        w_full_r       <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp  <= (aw_addr_r[1:0] == 2'b00 && aw_addr_r <= `ACS_ADDR_PMD) ?
                          `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
      end
      if (o_s_axi_bvalid & i_s_axi_bready) begin
        o_s_axi_bvalid  <= 1'b0;
        o_s_axi_awready <= 1'b1;
        o_s_axi_wready  <= 1'b1;
      end
      if (o_s_axi_arready & i_s_axi_arvalid) begin
        o_s_axi_arready <= 1'b0;
        o_s_axi_rvalid  <= 1'b1;
        o_s_axi_rdata   <= {24'h00_0000, rd_mux};
        o_s_axi_rresp   <= rd_ok ? `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
      end
      if (o_s_axi_rvalid & i_s_axi_rready) begin
        o_s_axi_rvalid  <= 1'b0;
        o_s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------------
  always @* begin
    rd_ok = 1'b1;
    case (i_s_axi_araddr)
      `ACS_ADDR_CTRL0: rd_mux = {1'b0, channel_select_r, go_r, converter_on_r};
      `ACS_ADDR_CTRL1: rd_mux = {trigger_source_sel_r, 7'h00};
      `ACS_ADDR_CTRL2: rd_mux = {result_justify_r, 1'b0, acq_time_sel_r, conv_clock_sel_r};
      `ACS_ADDR_RESH:  rd_mux = result_high_r;
      `ACS_ADDR_RESL:  rd_mux = result_low_r;
      `ACS_ADDR_STAT:  rd_mux = {7'h00, conv_done_flag_r};
      `ACS_ADDR_PMD:   rd_mux = {6'h00, irq_en_r, module_disable_r};
      default: begin
        rd_mux = 8'h00;
        rd_ok  = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------------------
  // module disable register, outside the held reset
  // ----------------------------------------------------------------------------
  always @(posedge i_clk) begin
    if (i_srst) begin
      module_disable_r <= 1'b0;
      irq_en_r         <= 1'b0;
    end else if (wr_ok && aw_addr_r == `ACS_ADDR_PMD) begin
      module_disable_r <= w_data_r[`ACS_PMD_DISABLE];
      irq_en_r         <= w_data_r[`ACS_PMD_IRQ_EN];
    end
  end

  // ----------------------------------------------------------------------------
  // control registers and sequencer
  // ----------------------------------------------------------------------------
  always @(posedge i_clk) begin
    if (core_rst) begin
      state_r              <= ST_IDLE;
      cnt_r                <= 5'd0;
      trial_r              <= `ACS_TRIAL_START;
      converter_on_r       <= 1'b0;
      go_r                 <= 1'b0;
      channel_select_r     <= `ACS_RST_CHS;
      trigger_source_sel_r <= 1'b0;
      result_justify_r     <= 1'b0;
      acq_time_sel_r       <= `ACS_RST_FIELD3;
      conv_clock_sel_r     <= `ACS_RST_FIELD3;
      conv_done_flag_r     <= 1'b0;
      sleep_off_r          <= 1'b0;
      result_high_r        <= `ACS_RST_REG;
      result_low_r         <= `ACS_RST_REG;
      cmp_meta_r           <= 1'b0;
      cmp_sync_r           <= 1'b0;
      o_wake               <= 1'b0;
    end else begin
      cmp_meta_r <= i_sar_cmp;
      cmp_sync_r <= cmp_meta_r;
      o_wake     <= 1'b0;
      if (!i_sleep)
        sleep_off_r <= 1'b0;
      if (wr_ctrl0) begin
        converter_on_r   <= w_data_r[`ACS_CTRL0_ON];
        channel_select_r <= w_data_r[`ACS_CTRL0_CHS_MSB:`ACS_CTRL0_CHS_LSB];
      end
      if (wr_ok && aw_addr_r == `ACS_ADDR_CTRL1)
        trigger_source_sel_r <= w_data_r[`ACS_CTRL1_TRIG];
      if (wr_ok && aw_addr_r == `ACS_ADDR_CTRL2) begin
        result_justify_r <= w_data_r[`ACS_CTRL2_JUST];
        acq_time_sel_r   <= w_data_r[`ACS_CTRL2_ACQ_MSB:`ACS_CTRL2_ACQ_LSB];
        conv_clock_sel_r <= w_data_r[`ACS_CTRL2_CLK_MSB:`ACS_CTRL2_CLK_LSB];
      end
      if (wr_ok && aw_addr_r == `ACS_ADDR_STAT && w_data_r[`ACS_STAT_DONE])
        conv_done_flag_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (start_req) begin
            go_r    <= 1'b1;
            state_r <= run_state;
            cnt_r   <= 5'd0;
            trial_r <= `ACS_TRIAL_START;
          end
        end
        ST_DELAY: begin
          cnt_r <= cnt_r + 5'd1;
          if (cnt_r == `ACS_INSTR_CLKS - 5'd1) begin
            cnt_r   <= 5'd0;
            state_r <= (acq_tads == 5'd0) ? ST_CONV : ST_ACQ;
          end
        end
        ST_ACQ: begin
          if (tad_tick) begin
            cnt_r <= cnt_r + 5'd1;
            if (cnt_r == acq_tads - 5'd1) begin
              cnt_r   <= 5'd0;
              state_r <= ST_CONV;
            end
          end
        end
        // comparator answer trails the trial by three clocks: /2 is too fast for valid bits
        ST_CONV: begin
          if (tad_tick) begin
            cnt_r <= cnt_r + 5'd1;
            if (cnt_r < 5'd10) begin
              // keep the bit when the input is at or above the trial level
              trial_r[bit_idx] <= cmp_sync_r;
              if (bit_idx != 4'd0)
                trial_r[bit_idx - 4'd1] <= 1'b1;
            end else begin
              cnt_r            <= 5'd0;
              state_r          <= ST_WAIT;
              go_r             <= 1'b0;
              conv_done_flag_r <= 1'b1;
              if (result_justify_r) begin
                result_high_r <= {6'h00, final_code[9:8]};
                result_low_r  <= final_code[7:0];
              end else begin
                result_high_r <= final_code[9:2];
                result_low_r  <= {final_code[1:0], 6'h00};
              end
              if (i_sleep && irq_en_r)
                o_wake <= 1'b1;
              if (i_sleep && !irq_en_r)
                sleep_off_r <= 1'b1;
            end
          end
        end
        ST_WAIT: begin
          if (start_req)
            go_r <= 1'b1;
          if (tad_tick) begin
            cnt_r <= cnt_r + 5'd1;
            if (cnt_r == `ACS_WAIT_TADS - 5'd1) begin
              cnt_r   <= 5'd0;
              trial_r <= `ACS_TRIAL_START;
              state_r <= (go_r | start_req) ? run_state : ST_IDLE;
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
      // software abort: results untouched, then the usual wait
      if (sw_go_clr && go_r) begin
        go_r <= 1'b0;
        if (state_r != ST_WAIT) begin
          state_r <= ST_WAIT;
          cnt_r   <= 5'd0;
        end
      end
      if (kill && state_r != ST_IDLE) begin
        state_r <= ST_IDLE;
        go_r    <= 1'b0;
        cnt_r   <= 5'd0;
      end
      if (i_sleep && !rc_sel)
        sleep_off_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------------
  // analog side controls
  // ----------------------------------------------------------------------------
  // registered from the state, so they trail it by one clock
  always @(posedge i_clk) begin
    if (core_rst) begin
      o_channel_sel <= `ACS_RST_CHS;
      o_ext_channel <= 1'b1;                                              // code zero is external
      o_sample_conn <= 1'b0;
      o_discharge   <= 1'b0;
      o_dac_trial   <= `ACS_TRIAL_START;
      o_analog_pwr  <= 1'b0;
    end else begin
      o_channel_sel <= channel_select_r;
      o_ext_channel <= (channel_select_r <= `ACS_CH_LAST_EXT);
      o_sample_conn <= powered & (state_r == ST_IDLE || state_r == ST_DELAY ||
                                  state_r == ST_ACQ);
      o_discharge   <= powered & (state_r == ST_WAIT);
      o_dac_trial   <= trial_r;
      o_analog_pwr  <= powered;
    end
  end

endmodule // acs_top

// ===== verif/acs_analog_model.sv
// analog front end model: comparator and free-running rc oscillator
`timescale 1ns/10ps
module acs_analog_model (
  input  wire       i_pwr,    // analog power
  input  wire [9:0] i_trial,  // trial code
  input  wire [9:0] i_vin,    // input level in codes
  output logic      o_cmp,    // comparator decision
  output logic      o_rc      // rc clock
);
  initial begin
    o_rc = 1'b0;
    forever #850 o_rc = ~o_rc;
  end
  // unpowered comparator wanders so a stale decision cannot pass as real
  assign o_cmp = i_pwr ? (i_vin >= i_trial) : o_rc;
endmodule // acs_analog_model

// ===== verif/acs_top_sva.sv
// port checker for the conversion sequencer
`timescale 1ns/10ps
module acs_top_chk (
  input wire        i_clk,           // clock
  input wire        i_srst,          // reset
  input wire        i_s_axi_bready,  // response ready
  input wire        i_s_axi_rready,  // read ready
  input wire        o_s_axi_bvalid,  // response valid
  input wire [1:0]  o_s_axi_bresp,   // response code
  input wire        o_s_axi_rvalid,  // read valid
  input wire [31:0] o_s_axi_rdata,   // read data
  input wire [4:0]  o_channel_sel,   // channel code
  input wire        o_ext_channel,   // external source
  input wire        o_sample_conn,   // hold link
  input wire        o_discharge,     // discharge
  input wire [9:0]  o_dac_trial,     // trial code
  input wire        o_analog_pwr,    // analog power
  input wire        o_wake           // wake pulse
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  // the array must stay discharged for at least three clocks
  sequence dis_hold;
    o_discharge [*3];
  endsequence
  reset_state_a: assert property ($fell(i_srst) |-> !o_s_axi_bvalid && !o_s_axi_rvalid
    && o_dac_trial == 10'h200 && !o_analog_pwr) else $error("state after reset wrong");
  rdata_upper_a: assert property (o_s_axi_rvalid |-> o_s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  ext_decode_a: assert property (o_ext_channel == (o_channel_sel <= 5'h1B))
    else $error("external channel flag wrong");
  dis_open_a: assert property (o_discharge |-> !o_sample_conn)
    else $error("channel linked during discharge");
  dis_len_a: assert property ($rose(o_discharge) |-> dis_hold)
    else $error("discharge wait too short");
  pwr_conn_a: assert property (!o_analog_pwr |-> !o_sample_conn)
    else $error("channel linked while unpowered");
  wake_once_a: assert property (o_wake |=> !o_wake)
    else $error("wake longer than one cycle");
  rd_hold_a: assert property (o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid
    && $stable(o_s_axi_rdata)) else $error("read data dropped");
  wr_hold_a: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid
    && $stable(o_s_axi_bresp)) else $error("write response dropped");
endmodule // acs_top_chk

bind acs_top acs_top_chk chk_u (.i_clk, .i_srst, .i_s_axi_bready, .i_s_axi_rready,
  .o_s_axi_bvalid, .o_s_axi_bresp, .o_s_axi_rvalid, .o_s_axi_rdata, .o_channel_sel,
  .o_ext_channel, .o_sample_conn, .o_discharge, .o_dac_trial, .o_analog_pwr, .o_wake);

// ===== verif/test_adc_conversion_sequencer.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/10ps
module test_adc_conversion_sequencer;
  logic        i_clk, i_srst, awv, wv, bre, arv, rre, cmp_t, ctu_t, slp;
  logic        awr, wrd, bv, arr, rv, cmp, rc, pw, dis, wk;
  logic [7:0]  awa, ara, eh, el;
  logic [31:0] wd, rdat;
  logic [31:0] rq[$], bq[$], rsq[$];
  logic [1:0]  bres, rres;
  logic [9:0]  vin, tr;
  int          err_total, num_checks;
  acs_top dut_u (.i_clk(i_clk), .i_srst(i_srst), .i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv),
    .o_s_axi_awready(awr), .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'h1), .i_s_axi_wvalid(wv),
    .o_s_axi_wready(wrd), .o_s_axi_bresp(bres), .o_s_axi_bvalid(bv), .i_s_axi_bready(bre),
    .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .o_s_axi_rdata(rdat),
    .o_s_axi_rresp(rres), .o_s_axi_rvalid(rv), .i_s_axi_rready(rre), .i_cmp_trig(cmp_t),
    .i_ctu_trig(ctu_t), .i_sleep(slp), .i_rc_clk(rc), .i_sar_cmp(cmp), .o_channel_sel(),
    .o_ext_channel(), .o_sample_conn(), .o_discharge(dis), .o_dac_trial(tr),
    .o_analog_pwr(pw), .o_wake(wk));
  acs_analog_model fe_u (.i_pwr(pw), .i_trial(tr), .i_vin(vin), .o_cmp(cmp), .o_rc(rc));
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  always @(posedge i_clk) begin
    if (rv && rre) begin
      chk("rdata", rdat, rq.pop_front());
      chk("rresp", {30'h0, rres}, rsq.pop_front());
    end
    if (bv && bre) chk("bresp", {30'h0, bres}, bq.pop_front());
  end
  task automatic wr_reg(input [7:0] a, input [7:0] d, input [1:0] r);
    bq.push_back({30'h0, r});
    @(posedge i_clk);
    awa <= a;
    wd <= {24'h0, d};
    {awv, wv, bre} <= 3'h7;
    do begin
      @(posedge i_clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
      if (bv) bre <= 1'b0;
    end while (awv || wv || bre);
  endtask
  task automatic rd_reg(input [7:0] a, input [7:0] e, input [1:0] r = 2'h0);
    rq.push_back({24'h0, e});
    rsq.push_back({30'h0, r});
    @(posedge i_clk);
    ara <= a;
    {arv, rre} <= 2'h3;
    do begin
      @(posedge i_clk);
      if (arr) arv <= 1'b0;
      if (rv) rre <= 1'b0;
    end while (arv || rre);
  endtask
  task automatic pulse(input bit ctu);
    @(posedge i_clk);
    if (ctu) ctu_t <= 1'b1;
    else cmp_t <= 1'b1;
    @(posedge i_clk);
    {cmp_t, ctu_t} <= 2'h0;
  endtask
  task automatic conv(input [2:0] c, input [2:0] q, input j, input int how);
    int unsigned r;
    logic [9:0]  v;
    r = $urandom;
    v = r[9:0];
    vin <= v;
    while (dis) @(posedge i_clk);
    wr_reg(8'h08, {j, 1'b0, q, c}, 2'h0);
    wr_reg(8'h04, {how == 2, 7'h00}, 2'h0);
    if (q == 3'h0) repeat (20) @(posedge i_clk);
    if (how == 0) wr_reg(8'h00, 8'h0F, 2'h0);
    else pulse(how == 2);
    rd_reg(8'h00, 8'h0F);
    while (!dis) @(posedge i_clk);
    eh = j ? {6'h00, v[9:8]} : v[9:2];
    el = j ? v[7:0] : {v[1:0], 6'h00};
    rd_reg(8'h00, 8'h0D);
    rd_reg(8'h14, 8'h01);
    rd_reg(8'h0C, eh);
    rd_reg(8'h10, el);
    wr_reg(8'h14, 8'h01, 2'h0);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_clk);
    err_total++;
    wrap_up;
  end
  initial begin
    void'($urandom(10507));
    {awv, wv, bre, arv, rre, cmp_t, ctu_t, slp} = 8'h00;
    {awa, ara, wd, vin} = 58'h0;
    i_srst = 1'b1;
    repeat (6) @(posedge i_clk);
    i_srst <= 1'b0;
    rd_reg(8'h00, 8'h00);
    wr_reg(8'h00, 8'h80, 2'h0);
    rd_reg(8'h00, 8'h00);
    wr_reg(8'h1C, 8'hFF, 2'h2);
    rd_reg(8'h1C, 8'h00, 2'h2);
    wr_reg(8'h00, 8'h0F, 2'h0);
    rd_reg(8'h00, 8'h0D);
    // the comparator loop needs three clocks, so /2 only serves the abort below
    for (int i = 0; i < 8; i++)
      conv(i == 0 ? 3'h4 : i[2:0], i[2:0], i[0], i % 3);
    // abort mid acquisition: old result must survive
    while (dis) @(posedge i_clk);
    wr_reg(8'h08, 8'h38, 2'h0);
    wr_reg(8'h00, 8'h0F, 2'h0);
    repeat (20) @(posedge i_clk);
    wr_reg(8'h00, 8'h0D, 2'h0);
    while (!dis) @(posedge i_clk);
    rd_reg(8'h14, 8'h00);
    rd_reg(8'h0C, eh);
    rd_reg(8'h10, el);
    wr_reg(8'h00, 8'h0C, 2'h0);
    pulse(1'b0);
    pulse(1'b1);
    rd_reg(8'h00, 8'h0C);
    wr_reg(8'h18, 8'h01, 2'h0);
    rd_reg(8'h00, 8'h00);
    wr_reg(8'h18, 8'h00, 2'h0);
    // sleep on the rc clock, fixed reference with a long acquisition
    vin <= 10'h2A5;
    wr_reg(8'h00, 8'h7D, 2'h0);
    for (int k = 0; k < 2; k++) begin
      while (dis) @(posedge i_clk);
      wr_reg(8'h18, {6'h00, k == 0, 1'b0}, 2'h0);
      wr_reg(8'h08, 8'hBB, 2'h0);
      wr_reg(8'h00, 8'h7F, 2'h0);
      slp <= 1'b1;
      while (!wk && pw) @(posedge i_clk);
      chk("wake", {31'h0, wk}, {31'h0, k == 0});
      chk("power", {31'h0, pw}, {31'h0, k == 0});
      rd_reg(8'h00, 8'h7D);
      rd_reg(8'h10, 8'hA5);
      wr_reg(8'h14, 8'h01, 2'h0);
      slp <= 1'b0;
    end
    // sleep on a divided clock aborts and powers down
    while (dis) @(posedge i_clk);
    wr_reg(8'h08, 8'h14, 2'h0);
    wr_reg(8'h00, 8'h7F, 2'h0);
    slp <= 1'b1;
    repeat (3) @(posedge i_clk);
    chk("power", {31'h0, pw}, 32'h0);
    rd_reg(8'h00, 8'h7D);
    rd_reg(8'h10, 8'hA5);
    slp <= 1'b0;
    wrap_up;
  end
endmodule // test_adc_conversion_sequencer
